// file: shared/phy_diag_regs.vh
// register offsets, field positions and reset values of the diagnostic block
`ifndef PHY_DIAG_REGS_VH
`define PHY_DIAG_REGS_VH
// register indices (byte address is four times the index)
`define FCNT_IDX        8'h14
`define RECNT_IDX       8'h15
`define STLB_IDX        8'h16
`define INTEN_IDX       8'h18
// byte addresses
`define FCNT_ADDR       12'h050
`define RECNT_ADDR      12'h054
`define STLB_ADDR       12'h058
`define INTEN_ADDR      12'h060
// control register fields
`define ERRMODE_BIT     14
`define CHKEN_BIT       13
`define GENEN_BIT       12
`define LOCK_BIT        11
`define SYNCLOSS_BIT    10
`define GENSTAT_BIT     9
`define PWRMODE_BIT     8
`define LBTX_BIT        6
`define LBSEL_MSB       4
// loopback select codes
`define LB_PCS_IN       5'h01
`define LB_PCS_OUT      5'h02
`define LB_DIGITAL      5'h04
`define LB_ANALOG       5'h08
`define LB_REVERSE      5'h10
// interrupt enable fields
`define FC_HF_EN_BIT    1
`define RE_HF_EN_BIT    0
// counter limits and half-full thresholds
`define FC_MAX          8'hFF
`define FC_HALF         8'h7F
`define RE_MAX          16'hFFFF
`define RE_HALF         16'h007F
// reset values
`define STLB_RESET      16'h0100
`define INTEN_RESET     2'h0
// bist checker lock threshold and error count limit
`define LOCK_GOOD       4'hF
`define BIST_ERR_MAX    8'hFF
`endif

// file: rtl/phy_diag_counters_bist_loopback.v
// diagnostic counters, bist generator and checker, loopback select
//
// Contract
// R01: false-carrier count is 8 bits, plus one per false carrier event
// R02: false-carrier count sticks at FFh until cleared
// R03: false-carrier count passing 7Fh raises a half-full event
// R04: reading either counter register clears that counter
// R05: 16-bit rx error count advances per error with carrier, rx valid, bad symbol
// R06: rx error count frozen during mii loopback
// R07: rx error count sticks at FFFFh until read
// R08: rx error count passing 7Fh raises a half-full event
// R09: error mode 1 wraps with pulse at max; 0 stops at max
// R10: checker enable bit compares received data to prbs
// R11: generator enable bit makes prbs packets; clearing stops it
// R12: lock bit reads 1 while checker is synchronised
// R13: sync-loss bit latches high until read
// R14: generator status bit reads 1 while generator runs
// R15: power-mode bit resets to 1, reads 0 in sleep
// R16: at 100M with tx bit set, mac tx also goes to line
// R17: software sets tx bit only while mii loopback is on
// R18: loopback select is one-hot five-bit field
// R19: per-counter enables gate half-full events to interrupt, reset 0
// R20: clear-on-read returns old value; coinciding event counts after clear
`timescale 1ns/1ps
`include "phy_diag_regs.vh"
module phy_diag_counters_bist_loopback #(
   parameter PKT_LEN = 16'd1000,
   parameter IPG_LEN = 16'd12
)(
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        falseCarrier,
   input  wire        rxCarrier,
   input  wire        rxDv,
   input  wire        rxSymErr,
   input  wire        miiLoopback,
   input  wire        speed100,
   input  wire        sleepMode,
   input  wire        rxBit,
   input  wire        rxBitValid,
   input  wire [3:0]  macTxd,
   input  wire        macTxEn,
   output reg  [3:0]  lineTxd_r,
   output reg         lineTxEn_r,
   output reg         genBit_r,
   output reg         genValid_r,
   output reg  [4:0]  loopSel_r,
   output reg         bistErrPulse_r,
   output reg         halfFullIrq_r
);

   // ----------------------------------------
   // register state
   // ----------------------------------------
   reg  [7:0]  fcCnt_r;
   reg  [15:0] reCnt_r;
   reg         errMode_r;
   reg         chkEn_r;
   reg         genEn_r;
   reg         lbTx_r;
   reg         syncLoss_r;
   reg         fcHfEn_r;
   reg         reHfEn_r;
   reg         fcHf_r;
   reg         reHf_r;
   reg  [14:0] genLfsr_r;
   reg  [14:0] chkLfsr_r;
   reg  [3:0]  goodRun_r;
   reg         locked_r;
   reg  [7:0]  bistErr_r;
   reg  [15:0] genCnt_r;
   reg         genState_r;
   reg  [1:0]  gstate_r;
   wire        apbAcc;
   wire        wrEn;
   wire        rdEn;
   wire        rdFc;
   wire        rdRe;
   wire        rdStlb;
   wire        mapped;
   wire        reEvt;
   wire        chkNew;
   wire        chkMiss;
   wire [15:0] stlbView;

   // generator fsm states
   localparam [1:0] G_IDLE = 2'b01;
   localparam [1:0] G_PKT  = 2'b10;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign apbAcc = psel & penable & pready;
   assign wrEn   = apbAcc & pwrite;
   assign rdEn   = psel & ~penable & ~pwrite;   // read side effects at the edge that loads prdata
   assign mapped = (paddr == `FCNT_ADDR) | (paddr == `RECNT_ADDR) |
                   (paddr == `STLB_ADDR) | (paddr == `INTEN_ADDR);
   assign rdFc   = rdEn & (paddr == `FCNT_ADDR);
   assign rdRe   = rdEn & (paddr == `RECNT_ADDR);
   assign rdStlb = rdEn & (paddr == `STLB_ADDR);

   // control register view
   assign stlbView = {1'b0, errMode_r, chkEn_r, genEn_r, locked_r, syncLoss_r,
                      genState_r, ~sleepMode, 1'b0, lbTx_r, 1'b0, loopSel_r}; // R12 R14 R15

   // ready one cycle after setup; error for unmapped addresses
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite)
         begin
            case (paddr)
               `FCNT_ADDR:  prdata <= {24'h000000, fcCnt_r};     // R20
               `RECNT_ADDR: prdata <= {16'h0000, reCnt_r};       // R20
               `STLB_ADDR:  prdata <= {16'h0000, stlbView};
               `INTEN_ADDR: prdata <= {30'h00000000, fcHfEn_r, reHfEn_r};
               default:     prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // writable control fields
   // ----------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         errMode_r <= 1'b0;
         chkEn_r   <= 1'b0;
         genEn_r   <= 1'b0;
         lbTx_r    <= 1'b0;
         loopSel_r <= 5'h00;
         fcHfEn_r  <= 1'b0;                                     // R19
         reHfEn_r  <= 1'b0;                                     // R19
      end
      else if (wrEn && paddr == `STLB_ADDR)
      begin
         errMode_r <= pwdata[`ERRMODE_BIT];
         chkEn_r   <= pwdata[`CHKEN_BIT];
         genEn_r   <= pwdata[`GENEN_BIT];
         lbTx_r    <= pwdata[`LBTX_BIT];                        // R17
         loopSel_r <= pwdata[`LBSEL_MSB:0];                     // R18
      end
      else if (wrEn && paddr == `INTEN_ADDR)
      begin
         fcHfEn_r  <= pwdata[`FC_HF_EN_BIT];
         reHfEn_r  <= pwdata[`RE_HF_EN_BIT];
      end
   end

   // ----------------------------------------
   // false carrier and rx error counters
   // ----------------------------------------
   assign reEvt = rxCarrier & rxDv & rxSymErr & ~miiLoopback;  // R05 R06

   // cleared where prdata takes the old count; an event there starts the new count at one
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fcCnt_r <= 8'h00;
         reCnt_r <= 16'h0000;
      end
      else
      begin
         if (rdFc)                                              // R04
            fcCnt_r <= {7'h00, falseCarrier};                   // R20
         else if (falseCarrier && fcCnt_r != `FC_MAX)           // R02
            fcCnt_r <= fcCnt_r + 8'h01;                         // R01
         if (rdRe)                                              // R04
            reCnt_r <= {15'h0000, reEvt};                       // R20
         else if (reEvt && reCnt_r != `RE_MAX)                  // R07
            reCnt_r <= reCnt_r + 16'h0001;                      // R05
      end
   end

   // half-full events on crossing the threshold, gated onto one output
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fcHf_r        <= 1'b0;
         reHf_r        <= 1'b0;
         halfFullIrq_r <= 1'b0;
      end
      else
      begin
         fcHf_r <= ~rdFc & falseCarrier & (fcCnt_r == `FC_HALF); // R03
         reHf_r <= ~rdRe & reEvt & (reCnt_r == `RE_HALF);        // R08
         halfFullIrq_r <= (fcHf_r & fcHfEn_r) | (reHf_r & reHfEn_r); // R19
      end
   end

   // ----------------------------------------
   // prbs packet generator
   // ----------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         gstate_r   <= G_IDLE;
         genCnt_r   <= 16'h0000;
         genLfsr_r  <= 15'h7FFF;
         genBit_r   <= 1'b0;
         genValid_r <= 1'b0;
         genState_r <= 1'b0;
      end
      else
      begin
         genState_r <= genEn_r;                                 // R14
         case (gstate_r)
            G_IDLE:
            begin
               genValid_r <= 1'b0;
               if (!genEn_r)                                    // R11
                  genCnt_r <= 16'h0000;
               else if (genCnt_r >= IPG_LEN)
               begin
                  gstate_r <= G_PKT;
                  genCnt_r <= 16'h0000;
               end
               else
                  genCnt_r <= genCnt_r + 16'h0001;
            end
            G_PKT:
            begin
               genLfsr_r  <= {genLfsr_r[13:0], genLfsr_r[14] ^ genLfsr_r[13]};
               genBit_r   <= genLfsr_r[14];                     // R11
               genValid_r <= 1'b1;
               if (!genEn_r || genCnt_r >= PKT_LEN - 16'd1)     // R11
               begin
                  gstate_r <= G_IDLE;
                  genCnt_r <= 16'h0000;
               end
               else
                  genCnt_r <= genCnt_r + 16'h0001;
            end
            default:
               gstate_r <= G_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // prbs checker: self-seeding lfsr, lock after a run of good bits
   // ----------------------------------------
   assign chkNew  = chkLfsr_r[14] ^ chkLfsr_r[13];
   assign chkMiss = rxBit ^ chkNew;

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         chkLfsr_r      <= 15'h0000;
         goodRun_r      <= 4'h0;
         locked_r       <= 1'b0;
         syncLoss_r     <= 1'b0;
         bistErr_r      <= 8'h00;
         bistErrPulse_r <= 1'b0;
      end
      else
      begin
         bistErrPulse_r <= 1'b0;
         if (rdStlb)                                            // R13
            syncLoss_r <= 1'b0;
         if (!chkEn_r)                                          // R10
         begin
            goodRun_r <= 4'h0;
            locked_r  <= 1'b0;
            bistErr_r <= 8'h00;
         end
         else if (rxBitValid)
         begin
            chkLfsr_r <= {chkLfsr_r[13:0], rxBit};              // R10
            if (!locked_r)
            begin
               goodRun_r <= chkMiss ? 4'h0 : goodRun_r + 4'h1;
               if (!chkMiss && goodRun_r == `LOCK_GOOD - 4'h1)
                  locked_r <= 1'b1;                             // R12
            end
            else if (chkMiss)
            begin
               if (bistErr_r == `BIST_ERR_MAX)
               begin
                  if (errMode_r)                                // R09
                  begin
                     bistErr_r      <= 8'h00;
                     bistErrPulse_r <= 1'b1;
                  end
               end
               else
                  bistErr_r <= bistErr_r + 8'h01;
               if (goodRun_r != 4'h0)
                  goodRun_r <= 4'h0;
               else
               begin
                  locked_r   <= 1'b0;                           // R12
                  syncLoss_r <= 1'b1;                           // R13
               end
            end
            else
               goodRun_r <= 4'h1;
         end
      end
   end

   // ----------------------------------------
   // line transmit path in mii loopback
   // ----------------------------------------
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         lineTxd_r  <= 4'h0;
         lineTxEn_r <= 1'b0;
      end
      else
      begin
         lineTxEn_r <= macTxEn & (~miiLoopback | (lbTx_r & speed100)); // R16
         lineTxd_r  <= macTxd;
      end
   end

endmodule // phy_diag_counters_bist_loopback

// file: dv/mac_tx_model.sv
// mac transmit side model: short nibble frames with gaps
`timescale 1ns/1ps
module mac_tx_model (
   input  logic       mclk,
   input  logic       sys_rst,
   output logic [3:0] macTxd,
   output logic       macTxEn
);
   logic [3:0] slot_r;
   // 8 nibbles on, 8 off; idle data toggles so stale values never look valid
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         slot_r  <= 4'h0;
         macTxEn <= 1'b0;
         macTxd  <= 4'h0;
      end
      else
      begin
         slot_r  <= slot_r + 4'h1;
         macTxEn <= ~slot_r[3];
         macTxd  <= slot_r[3] ? ~macTxd : macTxd + 4'h3;
      end
   end
endmodule // mac_tx_model

// file: dv/phy_diag_checker.sv
// port assertions of the diagnostic block
`timescale 1ns/1ps
module phy_diag_checker (
   input logic        mclk,
   input logic        sys_rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        miiLoopback,
   input logic        speed100,
   input logic [3:0]  macTxd,
   input logic        macTxEn,
   input logic [3:0]  lineTxd_r,
   input logic        lineTxEn_r,
   input logic        halfFullIrq_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_READY_CAUSE: assert property (!psel |=> !pready)
      else $error("ready without request");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   AST_LINE_PASS: assert property (!miiLoopback |=> lineTxEn_r == $past(macTxEn)
      && (!lineTxEn_r || lineTxd_r == $past(macTxd)))
      else $error("line tx not following mac");
   AST_LINE_SLOW: assert property (miiLoopback && !speed100 |=> !lineTxEn_r)
      else $error("line tx at 10M loopback");
   AST_IRQ_PULSE: assert property (halfFullIrq_r |=> !halfFullIrq_r)
      else $error("half-full event too long");
   cover property (pslverr);
   cover property (halfFullIrq_r);
   cover property (miiLoopback && lineTxEn_r);
endmodule // phy_diag_checker
bind phy_diag_counters_bist_loopback phy_diag_checker phy_diag_checker_inst (.mclk, .sys_rst,
   .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .miiLoopback, .speed100, .macTxd,
   .macTxEn, .lineTxd_r, .lineTxEn_r, .halfFullIrq_r);

// file: dv/phy_diag_counters_bist_loopback_tb.sv
// self-checking bench of the diagnostic block
`timescale 1ns/1ps
`include "phy_diag_regs.vh"
module phy_diag_counters_bist_loopback_tb;
   logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, pe;
   logic falseCarrier = 0, rxCarrier = 0, rxDv = 0, rxSymErr = 0, miiLoopback = 0;
   logic speed100 = 0, sleepMode = 0, rxBit = 0, rxBitValid = 0, flip = 0, macTxEn;
   logic lineTxEn_r, genBit_r, genValid_r, bistErrPulse_r, halfFullIrq_r;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [3:0]  macTxd, lineTxd_r;
   logic [4:0]  loopSel_r;
   int          err_count = 0, n_checks = 0, irqs = 0, cyc = 0, pulses = 0, p0 = 0;
   always #12.5 mclk = ~mclk;
   phy_diag_counters_bist_loopback #(.PKT_LEN(16'd8), .IPG_LEN(16'd4))
      phy_diag_counters_bist_loopback_inst (.mclk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .falseCarrier, .rxCarrier, .rxDv,
      .rxSymErr, .miiLoopback, .speed100, .sleepMode, .rxBit, .rxBitValid, .macTxd,
      .macTxEn, .lineTxd_r, .lineTxEn_r, .genBit_r, .genValid_r, .loopSel_r,
      .bistErrPulse_r, .halfFullIrq_r);
   mac_tx_model mac_tx_model_inst (.mclk, .sys_rst, .macTxd, .macTxEn);
   // prbs loop from generator to checker, optionally corrupted
   always @(posedge mclk)
   begin
      rxBit <= genBit_r ^ flip;
      rxBitValid <= genValid_r;
   end
   // event counting and hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (halfFullIrq_r === 1'b1) irqs++;
      if (bistErrPulse_r === 1'b1) pulses++;
      if (cyc == 90000)
      begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", s, x, g);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 0;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
      bus(0, a, 0);
      chk("read", x, q & m);
   endtask
   task automatic ev(input int n);
      repeat (n)
      begin
         falseCarrier <= 1;
         @(posedge mclk);
      end
      falseCarrier <= 0;
      @(posedge mclk);
   endtask
   task automatic rxe(input logic lb, input int n);
      {rxCarrier, rxDv, rxSymErr, miiLoopback} <= {3'h7, lb};
      repeat (n) @(posedge mclk);
      {rxCarrier, rxDv, rxSymErr, miiLoopback} <= 4'h0;
      @(posedge mclk);
   endtask
   // single flipped bits at packet start, spaced so the checker relocks in between
   task automatic hits(input int n);
      repeat (n)
      begin
         while (genValid_r !== 1'b0)
            @(posedge mclk);
         while (genValid_r !== 1'b1)
            @(posedge mclk);
         flip <= 1;
         @(posedge mclk);
         flip <= 0;
         repeat (60) @(posedge mclk);
      end
   endtask
   // line output against mac input of the previous cycle
   task automatic line(input logic f);
      @(posedge mclk);
      pe = macTxEn;
      repeat (30)
      begin
         @(posedge mclk);
         chk("lineTxEn", {31'h0, f & pe}, {31'h0, lineTxEn_r});
         pe = macTxEn;
      end
   endtask
   initial
   begin
      repeat (6) @(posedge mclk);
      sys_rst <= 0;
      @(posedge mclk);
      rd(`STLB_ADDR, 32'h0000_0100);
      rd(`INTEN_ADDR, 32'h0);
      rd(`FCNT_ADDR, 32'h0);
      bus(0, 12'h05C, 0);
      chk("slverr", 32'h1, {31'h0, e});
      sleepMode <= 1;
      @(posedge mclk);
      rd(`STLB_ADDR, 32'h0);
      sleepMode <= 0;
      bus(1, `INTEN_ADDR, 32'h3);
      rd(`INTEN_ADDR, 32'h3);
      ev(3);
      rd(`FCNT_ADDR, 32'h3);
      rd(`FCNT_ADDR, 32'h0);
      falseCarrier <= 1;
      rd(`FCNT_ADDR, 32'h0);
      falseCarrier <= 0;
      rd(`FCNT_ADDR, 32'h3);
      ev(300);
      rd(`FCNT_ADDR, 32'hFF);
      chk("irqs", 32'h1, irqs);
      rxe(1, 10);
      rxe(0, 5);
      rd(`RECNT_ADDR, 32'h5);
      rxe(0, 65540);
      rd(`RECNT_ADDR, 32'hFFFF);
      chk("irqs", 32'h2, irqs);
      bus(1, `INTEN_ADDR, 32'h0);
      ev(130);
      rd(`FCNT_ADDR, 32'h82);
      chk("irqs", 32'h2, irqs);
      for (int i = 0; i < 5; i++)
      begin
         bus(1, `STLB_ADDR, 32'h1 << i);
         rd(`STLB_ADDR, 32'h100 | (32'h1 << i));
         chk("loopSel", 32'h1 << i, {27'h0, loopSel_r});
      end
      bus(1, `STLB_ADDR, 32'h7000);
      repeat (80) @(posedge mclk);
      rd(`STLB_ADDR, 32'h7B00, 32'h7F00);
      flip <= 1;
      repeat (30) @(posedge mclk);
      flip <= 0;
      repeat (80) @(posedge mclk);
      rd(`STLB_ADDR, 32'h7F00, 32'h7F00);
      rd(`STLB_ADDR, 32'h7B00, 32'h7F00);
      p0 = pulses;
      hits(100);
      chk("bistPulse", 32'h1, pulses - p0);
      bus(1, `STLB_ADDR, 32'h3000);
      p0 = pulses;
      hits(100);
      chk("bistPulse", 32'h0, pulses - p0);
      bus(1, `STLB_ADDR, 32'h0);
      repeat (30) @(posedge mclk);
      rd(`STLB_ADDR, 32'h0, 32'h1A00);
      chk("genValid", 32'h0, {31'h0, genValid_r});
      miiLoopback <= 1;
      speed100 <= 1;
      @(posedge mclk);
      bus(1, `STLB_ADDR, 32'h40);
      line(1);
      bus(1, `STLB_ADDR, 32'h0);
      line(0);
      summarize();
   end
endmodule // phy_diag_counters_bist_loopback_tb
